// *** design/plrc_pkg.sv ***
package plrc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [15:0] PLRC_OFF_CTRL      = 16'h0284; // low half-word at 0x284, high at 0x286
  localparam int          PLRC_ADDR_W        = 16;

  // ************************************************************
  // field positions (bit 0 is the msb, as the register is drawn)
  // ************************************************************
  localparam int PLRC_MFN_LSB   = 27; // numerator, drawn bits 0-4
  localparam int PLRC_MFD_LSB   = 22; // denominator minus one, bits 5-9
  localparam int PLRC_PDIV_LSB  = 20; // post-divider select, bits 10-11
  localparam int PLRC_MFI_LSB   = 16; // integer multiplier, bits 12-15
  localparam int PLRC_TIMER_EXPIRED_OUTPUT_BIT  = 14; // timer expired, bit 17
  localparam int PLRC_SYSTEM_CLOCK_SOURCE_SELECT_BIT  = 10; // clock source, bit 21
  localparam int PLRC_CSR_BIT   = 7;  // checkstop reset enable, bit 24
  localparam int PLRC_PDF_LSB   = 1;  // pre-division, bits 27-30
  localparam int PLRC_ORD_BIT   = 0;  // modulator order, bit 31

  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [4:0] PLRC_MFN_RST  = 5'h00;
  localparam logic [4:0] PLRC_MFD_RST  = 5'h01;
  localparam logic [1:0] PLRC_PDIV_RST = 2'h1;
  localparam logic [3:0] PLRC_MFI_MIN  = 4'h5;
  localparam logic [1:0] PLRC_PDIV_RSV = 2'h3;
  // power-on straps: integer multiplier and pre-division per pin code 00,01,10,11
  localparam logic [3:0] PLRC_MFI_POR [4] = '{4'h8, 4'hF, 4'h6, 4'hF};
  localparam logic [3:0] PLRC_PDF_POR [4] = '{4'h0, 4'h0, 4'h2, 4'h0};

  // checkstop outcome
  typedef enum logic [2:0] {
    PLRC_CS_NONE  = 3'b001,
    PLRC_CS_DEBUG = 3'b010,
    PLRC_CS_RESET = 3'b100
  } plrc_cs_t;
endpackage

// *** design/plrc_ctrl.sv ***
`timescale 1ns/1ns
// Function
// - zero numerator disables the fractional divider.
// - post-divider select 00/01/10 divides by 1/2/4; 11 reserved.
// - integer multiplier below five is used as five.
// - timer expired status set by timer, alarm, decrementer or reset.
// - writing one clears timer expired status; zero leaves it.
// - clock source selects high (0) or low (1) divider; hard reset clears.
// - checkstop reset enable makes checkstop cause automatic reset.
// - debug enable wins: debug mode; reset only if enable and not debug.
// - debug mode entered at reset suppresses automatic checkstop reset.
// - order bit picks first or second order; ignored when numerator zero.
// - register responds to hard reset and soft reset.
// - power-on multiplier and pre-division come from mode clock pins.
// - pin codes 00/01/10/11 give 8/0, 15/0, 6/2, 15/0.
// - every power-on gives post-divider select 01, numerator 0, denominator field 1.
module plrc_ctrl
  import plrc_pkg::*;
(
  // clock and resets
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   hard_reset_pulse,
  input  wire logic                   soft_reset_pulse,
  // configuration straps
  input  wire logic                   mode_clock_pin_one,
  input  wire logic                   mode_clock_pin_two,
  // register port
  input  wire logic [PLRC_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [31:0]            reg_wdata,
  output logic      [31:0]            reg_rdata,
  output logic                        reg_hit,
  // status events
  input  wire logic                   periodic_timer_expired,
  input  wire logic                   timebase_alarm,
  input  wire logic                   decrementer_irq,
  // checkstop handling
  input  wire logic                   checkstop_entry,
  input  wire logic                   checkstop_debug_enable,
  input  wire logic                   debug_at_reset,
  output logic                        auto_reset_req,
  output logic                        debug_mode_req,
  // pll controls
  output logic      [3:0]             pll_int_mult,
  output logic      [4:0]             pll_frac_num,
  output logic      [5:0]             pll_frac_den,
  output logic      [4:0]             pll_pre_div,
  output logic      [2:0]             pll_post_ratio,
  output logic                        pll_frac_enable,
  output logic                        pll_second_order,
  output logic                        timer_expired_output,
  output logic                        system_clock_source_select
);

  // ************************************************************
  // register fields
  // ************************************************************
  logic [4:0] mfn_reg;
  logic [4:0] mfd_reg;
  logic [1:0] pdiv_reg;
  logic [3:0] mfi_reg;
  logic       timer_expired_output_reg;
  logic       system_clock_source_select_reg;
  logic       csr_reg;
  logic [3:0] pdf_reg;
  logic       ord_reg;
  logic       por_done_reg;
  logic       dbg_lock_reg;
  logic [1:0] strap;
  logic       wr_hit;
  logic       timer_expired_output_set;
  logic [3:0] mfi_eff;
  plrc_cs_t   cs_next;

  assign strap  = {mode_clock_pin_one, mode_clock_pin_two};
  assign wr_hit = reg_wr && (reg_addr == PLRC_OFF_CTRL);
  assign reg_hit = (reg_wr || reg_rd) && (reg_addr == PLRC_OFF_CTRL);

  // ************************************************************
  // pll configuration fields
  // ************************************************************
  // asynchronous reset only loads constants; straps land on the first enabled edge after release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      por_done_reg <= 1'b0;
      mfn_reg      <= PLRC_MFN_RST;
      mfd_reg      <= PLRC_MFD_RST;
      pdiv_reg     <= PLRC_PDIV_RST;
      mfi_reg      <= 4'h0;
      pdf_reg      <= 4'h0;
      ord_reg      <= 1'b0;
      csr_reg      <= 1'b0;
    end else if (clk_en) begin
      if (!por_done_reg) begin
        por_done_reg <= 1'b1;
        mfn_reg      <= PLRC_MFN_RST;
        mfd_reg      <= PLRC_MFD_RST;
        pdiv_reg     <= PLRC_PDIV_RST;
        mfi_reg      <= PLRC_MFI_POR[strap];
        pdf_reg      <= PLRC_PDF_POR[strap];
      end else if (hard_reset_pulse) begin
        pdf_reg      <= 4'h0;
        ord_reg      <= 1'b0;
      end else if (wr_hit) begin
        mfn_reg      <= reg_wdata[PLRC_MFN_LSB +: 5];
        mfd_reg      <= reg_wdata[PLRC_MFD_LSB +: 5];
        // reserved post-divider code is refused, previous value kept
        if (reg_wdata[PLRC_PDIV_LSB +: 2] != PLRC_PDIV_RSV) begin
          pdiv_reg   <= reg_wdata[PLRC_PDIV_LSB +: 2];
        end
        mfi_reg      <= reg_wdata[PLRC_MFI_LSB +: 4];
        pdf_reg      <= reg_wdata[PLRC_PDF_LSB +: 4];
        ord_reg      <= reg_wdata[PLRC_ORD_BIT];
        csr_reg      <= reg_wdata[PLRC_CSR_BIT];
      end
    end
  end

  // ************************************************************
  // timer expired status, write one to clear
  // ************************************************************
  // soft reset counts as a system reset; set beats a simultaneous clear
  assign timer_expired_output_set = periodic_timer_expired || timebase_alarm || decrementer_irq ||
                    hard_reset_pulse || soft_reset_pulse || !por_done_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timer_expired_output_reg <= 1'b1;
    end else if (clk_en) begin
      if (timer_expired_output_set) begin
        timer_expired_output_reg <= 1'b1;
      end else if (wr_hit && reg_wdata[PLRC_TIMER_EXPIRED_OUTPUT_BIT]) begin
        timer_expired_output_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // clock source select
  // ************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      system_clock_source_select_reg <= 1'b0;
    end else if (clk_en) begin
      if (hard_reset_pulse || soft_reset_pulse) begin
        system_clock_source_select_reg <= 1'b0;
      end else if (wr_hit) begin
        system_clock_source_select_reg <= reg_wdata[PLRC_SYSTEM_CLOCK_SOURCE_SELECT_BIT];
      end
    end
  end

  // ************************************************************
  // debug-at-reset latch
  // ************************************************************
  // a debug entry at reset blocks checkstop resets until the next hard reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dbg_lock_reg <= 1'b0;
    end else if (clk_en) begin
      if (debug_at_reset) begin
        dbg_lock_reg <= 1'b1;
      end else if (hard_reset_pulse) begin
        dbg_lock_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // checkstop outcome
  // ************************************************************
  always_comb begin
    cs_next = PLRC_CS_NONE;
    if (checkstop_entry) begin
      if (checkstop_debug_enable) begin
        cs_next = PLRC_CS_DEBUG;
      end else if (csr_reg && !dbg_lock_reg && !debug_at_reset) begin
        cs_next = PLRC_CS_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      auto_reset_req <= 1'b0;
      debug_mode_req <= 1'b0;
    end else if (clk_en) begin
      case (cs_next)
        PLRC_CS_DEBUG: begin
          auto_reset_req <= 1'b0;
          debug_mode_req <= 1'b1;
        end
        PLRC_CS_RESET: begin
          auto_reset_req <= 1'b1;
          debug_mode_req <= 1'b0;
        end
        default: begin
          auto_reset_req <= 1'b0;
          debug_mode_req <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // derived pll controls
  // ************************************************************
  assign mfi_eff = (mfi_reg < PLRC_MFI_MIN) ? PLRC_MFI_MIN : mfi_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pll_int_mult     <= PLRC_MFI_MIN;
      pll_frac_num     <= 5'h00;
      pll_frac_den     <= 6'h02;
      pll_pre_div      <= 5'h01;
      pll_post_ratio   <= 3'h2;
      pll_frac_enable  <= 1'b0;
      pll_second_order <= 1'b0;
    end else if (clk_en) begin
      pll_int_mult     <= mfi_eff;
      pll_frac_num     <= mfn_reg;
      pll_frac_den     <= {1'b0, mfd_reg} + 6'h01;
      pll_pre_div      <= {1'b0, pdf_reg} + 5'h01;
      pll_post_ratio   <= 3'h1 << pdiv_reg;
      pll_frac_enable  <= (mfn_reg != 5'h00);
      pll_second_order <= ord_reg && (mfn_reg != 5'h00);
    end
  end

  assign timer_expired_output       = timer_expired_output_reg;
  assign system_clock_source_select = system_clock_source_select_reg;

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd && reg_addr == PLRC_OFF_CTRL) begin
        reg_rdata[PLRC_MFN_LSB +: 5]  <= mfn_reg;
        reg_rdata[PLRC_MFD_LSB +: 5]  <= mfd_reg;
        reg_rdata[PLRC_PDIV_LSB +: 2] <= pdiv_reg;
        reg_rdata[PLRC_MFI_LSB +: 4]  <= mfi_reg;
        reg_rdata[PLRC_TIMER_EXPIRED_OUTPUT_BIT]      <= timer_expired_output_reg;
        reg_rdata[PLRC_SYSTEM_CLOCK_SOURCE_SELECT_BIT]      <= system_clock_source_select_reg;
        reg_rdata[PLRC_CSR_BIT]       <= csr_reg;
        reg_rdata[PLRC_PDF_LSB +: 4]  <= pdf_reg;
        reg_rdata[PLRC_ORD_BIT]       <= ord_reg;
      end
    end
  end

endmodule // plrc_ctrl

// *** test/plrc_ctrl_checker.sv ***
`timescale 1ns/1ns
module plrc_ctrl_checker
  import plrc_pkg::*;
(
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   nrst,
  input wire logic                   clk_en,
  // inputs of the block
  input wire logic                   hard_reset_pulse,
  input wire logic [PLRC_ADDR_W-1:0] reg_addr,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_wdata,
  input wire logic                   periodic_timer_expired,
  input wire logic                   timebase_alarm,
  input wire logic                   decrementer_irq,
  input wire logic                   checkstop_entry,
  input wire logic                   checkstop_debug_enable,
  // outputs of the block
  input wire logic [31:0]            reg_rdata,
  input wire logic                   auto_reset_req,
  input wire logic                   debug_mode_req,
  input wire logic [3:0]             pll_int_mult,
  input wire logic [4:0]             pll_frac_num,
  input wire logic [2:0]             pll_post_ratio,
  input wire logic                   pll_frac_enable,
  input wire logic                   pll_second_order,
  input wire logic                   timer_expired_output,
  input wire logic                   system_clock_source_select
);
  // ************************************************************
  // port relations, all in the one clock domain
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // read data must not leak outside its single answer cycle
  rd_idle_zero_a: assert property (clk_en && !(reg_rd && reg_addr == PLRC_OFF_CTRL) |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  post_ratio_a: assert property (clk_en && reg_wr && reg_addr == PLRC_OFF_CTRL && !hard_reset_pulse &&
    reg_wdata[21:20] != 2'h3 |-> ##2 pll_post_ratio == (3'h1 << $past(reg_wdata[21:20], 2))) else $error("post ratio wrong");
  mfi_floor_a: assert property (pll_int_mult >= PLRC_MFI_MIN) else $error("integer multiplier below floor");
  frac_gate_a: assert property (pll_frac_enable == (pll_frac_num != 5'h00)) else $error("fraction enable wrong");
  order_gate_a: assert property (pll_second_order |-> pll_frac_enable) else $error("order used without fraction");
  timer_expired_output_set_a: assert property (clk_en && (periodic_timer_expired || timebase_alarm || decrementer_irq)
    |=> timer_expired_output) else $error("expired status not set");
  debug_wins_a: assert property (clk_en && checkstop_entry && checkstop_debug_enable
    |=> debug_mode_req && !auto_reset_req) else $error("debug enable did not win");
  idle_quiet_a: assert property (clk_en && !checkstop_entry |=> !auto_reset_req && !debug_mode_req)
    else $error("checkstop outcome without checkstop");
  system_clock_source_select_hard_a: assert property (clk_en && hard_reset_pulse |=> !system_clock_source_select)
    else $error("clock source not cleared by hard reset");
endmodule // plrc_ctrl_checker

bind plrc_ctrl plrc_ctrl_checker u_chk (.clk_sys, .nrst, .clk_en, .hard_reset_pulse, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .periodic_timer_expired, .timebase_alarm, .decrementer_irq, .checkstop_entry, .checkstop_debug_enable,
  .reg_rdata, .auto_reset_req, .debug_mode_req, .pll_int_mult, .pll_frac_num, .pll_post_ratio, .pll_frac_enable,
  .pll_second_order, .timer_expired_output, .system_clock_source_select);

// *** test/plrc_ctrl_tb.sv ***
`timescale 1ns/1ns
module plrc_ctrl_tb;
  import plrc_pkg::*;
  // base word: denominator field 1, post select 01, integer 8
  localparam logic [31:0] BASE = 32'h00580000;
  // drive side, all changed at the falling edge
  logic        clk_sys    = 1'b0;
  logic        nrst       = 1'b0;
  logic [1:0]  mck        = 2'h0;
  logic [5:0]  ev         = 6'h00; // hard, soft, timer, alarm, decrementer, checkstop
  logic        dbg        = 1'b0;
  logic        dar        = 1'b0;
  logic        ce         = 1'b1;
  logic        w_en       = 1'b0;
  logic        r_en       = 1'b0;
  logic [15:0] addr       = 16'h0000;
  logic [31:0] wd         = 32'h0;
  logic [24:0] ex;
  int          n_errors   = 0;
  int          num_checks = 0;
  // observe side; fl = frac enable, second order, expired, source, auto reset, debug
  wire  [31:0] rdata;
  wire  [3:0]  im;
  wire  [4:0]  fn, pd;
  wire  [5:0]  fd, fl;
  wire  [2:0]  pr;
  wire         hit;

  plrc_ctrl dut (.clk_sys(clk_sys), .nrst(nrst), .clk_en(ce), .hard_reset_pulse(ev[0]), .soft_reset_pulse(ev[1]),
    .mode_clock_pin_one(mck[1]), .mode_clock_pin_two(mck[0]), .reg_addr(addr), .reg_wr(w_en), .reg_rd(r_en),
    .reg_wdata(wd), .reg_rdata(rdata), .reg_hit(hit), .periodic_timer_expired(ev[2]), .timebase_alarm(ev[3]),
    .decrementer_irq(ev[4]), .checkstop_entry(ev[5]), .checkstop_debug_enable(dbg), .debug_at_reset(dar),
    .auto_reset_req(fl[1]), .debug_mode_req(fl[0]), .pll_int_mult(im), .pll_frac_num(fn), .pll_frac_den(fd),
    .pll_pre_div(pd), .pll_post_ratio(pr), .pll_frac_enable(fl[5]), .pll_second_order(fl[4]),
    .timer_expired_output(fl[3]), .system_clock_source_select(fl[2]));

  always #4 clk_sys = ~clk_sys;

  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // returns one edge after the write lands, so pll outputs are settled
  task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    addr = a;
    wd = d;
    w_en = 1'b1;
    @(negedge clk_sys);
    w_en = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic read_reg(input logic [15:0] a, input logic [31:0] e, input string nm);
    @(negedge clk_sys);
    addr = a;
    r_en = 1'b1;
    @(negedge clk_sys);
    // strobe still up here, so the combinational hit flag is settled
    chk("hit", {31'h0, hit}, {31'h0, a == PLRC_OFF_CTRL});
    r_en = 1'b0;
    chk(nm, rdata, e);
  endtask
  // one-cycle event; returns where the one-cycle answers are visible
  task automatic pulse(input int k);
    @(negedge clk_sys);
    ev[k] = 1'b1;
    @(negedge clk_sys);
    ev[k] = 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    // every strap code, ending on 00 so later tests start from it
    for (int c = 3; c >= 0; c--) begin
      mck = c[1:0];
      nrst = 1'b0;
      repeat (12) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (3) @(negedge clk_sys);
      ex = {PLRC_MFI_POR[c], {1'b0, PLRC_PDF_POR[c]} + 5'h01, 3'h2, 5'h00, 6'h02, 2'b01};
      chk("por", {7'h00, im, pd, pr, fn, fd, fl[5], fl[3]}, {7'h00, ex});
    end
    read_reg(PLRC_OFF_CTRL, BASE | 32'h00004000, "ctrl");
    write_reg(PLRC_OFF_CTRL, BASE);
    chk("timer_expired_output", {31'h0, fl[3]}, 32'h1);
    for (int k = 2; k < 5; k++) begin
      write_reg(PLRC_OFF_CTRL, BASE | 32'h00004000);
      chk("timer_expired_output", {31'h0, fl[3]}, 32'h0);
      pulse(k);
      chk("timer_expired_output", {31'h0, fl[3]}, 32'h1);
    end
    for (int s = 0; s < 4; s++) begin
      write_reg(PLRC_OFF_CTRL, {BASE[31:22], s[1:0], BASE[19:0]});
      chk("post", {29'h0, pr}, 32'h1 << (s == 3 ? 2 : s));
    end
    write_reg(PLRC_OFF_CTRL, {BASE[31:20], 4'h4, BASE[15:0]});
    chk("mult", {28'h0, im}, 32'h5);
    write_reg(PLRC_OFF_CTRL, {5'h03, 5'h09, 2'h1, 4'hE, 11'h000, 4'h2, 1'b1});
    chk("frac", {7'h00, im, fn, fd, pd, pr, fl[5:4]}, {7'h00, 4'hE, 5'h03, 6'h0A, 5'h03, 3'h2, 2'b11});
    write_reg(PLRC_OFF_CTRL, {BASE[31:1], 1'b1});
    chk("nofrac", {30'h0, fl[5:4]}, 32'h0);
    write_reg(PLRC_OFF_CTRL, BASE | 32'h00000400);
    chk("system_clock_source_select", {31'h0, fl[2]}, 32'h1);
    pulse(1);
    chk("soft", {30'h0, fl[3:2]}, 32'h2);
    write_reg(PLRC_OFF_CTRL, BASE | 32'h00000404);
    pulse(0);
    @(negedge clk_sys);
    chk("hard", {25'h0, pd, fl[3:2]}, {25'h0, 5'h01, 2'b10});
    for (int i = 0; i < 4; i++) begin
      write_reg(PLRC_OFF_CTRL, BASE | {24'h0, i[1], 7'h00});
      dbg = i[0];
      pulse(5);
      chk("cstop", {30'h0, fl[1:0]}, {30'h0, i[1] & ~i[0], i[0]});
    end
    dbg = 1'b0;
    dar = 1'b1;
    @(negedge clk_sys);
    dar = 1'b0;
    pulse(5);
    chk("lock", {30'h0, fl[1:0]}, 32'h0);
    pulse(0);
    pulse(5);
    chk("unlock", {30'h0, fl[1:0]}, 32'h2);
    write_reg(16'h0288, 32'hFFFFFFFF);
    read_reg(16'h0288, 32'h0, "unmapped");
    // clock enable low: a write must not land and outputs must hold
    ce = 1'b0;
    write_reg(PLRC_OFF_CTRL, 32'h005C0400);
    chk("freeze", {26'h0, im, fl[3:2]}, {26'h0, 4'h8, 2'b10});
    ce = 1'b1;
    read_reg(PLRC_OFF_CTRL, BASE | 32'h00004080, "ctrl");
    results();
  end

  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    results();
  end
endmodule // plrc_ctrl_tb
